// [rtl/adc_ctl_pkg.sv]
// shared constants and types for the dual converter conversion control
package adc_ctl_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned DATA_W  = 16;
    localparam int unsigned ACC_W   = 18;
    localparam int unsigned CNT_W   = 18;
    localparam int unsigned FIFO_DEPTH = 16;

    // data_ready_delay: internal conversion time
    localparam int unsigned CONV_NS      = 250;
    localparam int unsigned RST_MIN_NS   = 40;
    localparam int unsigned PD_MIN_NS    = 2000;
    localparam int unsigned RST_WAKE_NS  = 1000;
    localparam int unsigned PD_WAKE_NS   = 1000000;

    localparam logic [CNT_W-1:0] CONV_CYC =
        CNT_W'((CONV_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] RST_MIN_CYC =
        CNT_W'((RST_MIN_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] PD_MIN_CYC =
        CNT_W'((PD_MIN_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] RST_WAKE_CYC =
        CNT_W'((RST_WAKE_NS * CLK_MHZ + 999) / 1000);
    localparam int unsigned PD_WAKE_CYC =
        (PD_WAKE_NS * CLK_MHZ + 999) / 1000;

    // averaging_config codes
    localparam logic [1:0] AVG_TWO     = 2'h2;
    localparam logic [1:0] AVG_FOUR    = 2'h3;
    localparam logic [1:0] AVG_DEFAULT = 2'h0;
    localparam logic       WIDE_DEFAULT = 1'b0;

    // synchronised pin bundle layout
    localparam int unsigned PIN_N   = 4;
    localparam int unsigned PIN_CST = 0;
    localparam int unsigned PIN_PD  = 1;
    localparam int unsigned PIN_CS  = 2;
    localparam int unsigned PIN_SCK = 3;
    localparam logic [PIN_N-1:0] PIN_RESET = 4'h6;

    typedef enum logic [1:0] {
        ST_ACQ  = 2'h0,
        ST_CNV  = 2'h1,
        ST_LOW  = 2'h3,
        ST_WAKE = 2'h2
    } state_type;
endpackage

// [rtl/pin_sync.sv]
// two flip-flop synchroniser for a bundle of pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int unsigned     WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             core_clk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // pin_sync
`default_nettype wire

// [rtl/word_fifo.sv]
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             core_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;

    wire full_w  = (wr_q[AW] != rd_q[AW]) &&
                   (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty_w = (wr_q == rd_q);
    wire push_w  = in_valid_i && !full_w;
    wire pop_w   = out_ready_i && !empty_w;

    assign in_ready_o  = !full_w;
    assign out_valid_o = !empty_w;
    assign out_data_o  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge core_clk_i) begin
        if (push_w) begin
            mem_q[wr_q[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (flush_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push_w);
            rd_q <= rd_q + (AW+1)'(pop_w);
        end
    end
endmodule // word_fifo
`default_nettype wire

// [rtl/adc_conv_ctrl.sv]
// conversion control, averaging and serial readout of a dual converter
// Overview of operation
// - code 10b outputs mean of two samples
// - two-sample ready follows second start edge
// - code 11b outputs mean of four samples
// - four-sample ready follows fourth start edge
// - four-sample result is sum divided by four
// - acquisition after reset, wake, conversion done
// - reset falling aborts; start rise converts
// - conversion timed by internal clock only
// - short low pulse resets, config to defaults
// - long low pulse powers down, defaults
// - release from power-down waits wake delay
// - default readout is mode-0 dual lane
// - zero-latency select waits for ready
// - zero-latency frame shifts current sample
// - wide-read frame shifts previous sample
// - shared pin: low when selected or in wide read, else ready
`timescale 1ns/1ps
`default_nettype none
module adc_conv_ctrl #(
    parameter int unsigned PD_WAKE_CYCLES = adc_ctl_pkg::PD_WAKE_CYC
) (
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        conversion_start_i,
    input  wire logic        powerdown_reset_n_i,
    input  wire logic        cs_n_i,
    input  wire logic        sclk_i,
    input  wire logic [15:0] sample_a_i,
    input  wire logic [15:0] sample_b_i,
    input  wire logic        config_write_i,
    input  wire logic [1:0]  average_count_select_i,
    input  wire logic        wide_read_i,
    output logic             ready_strobe_o,
    output logic             sdo_a_o,
    output logic             sdo_b_o,
    output logic             sdo_oe_o,
    output logic             acquiring_o,
    output logic             converting_o,
    output logic             powered_down_o,
    output logic [1:0]       averaging_config_o,
    output logic             wide_read_o
);
    localparam int unsigned DW  = adc_ctl_pkg::DATA_W;
    localparam int unsigned AW  = adc_ctl_pkg::ACC_W;
    localparam int unsigned CW  = adc_ctl_pkg::CNT_W;
    localparam int unsigned CST = adc_ctl_pkg::PIN_CST;
    localparam int unsigned PD  = adc_ctl_pkg::PIN_PD;
    localparam int unsigned CS  = adc_ctl_pkg::PIN_CS;
    localparam int unsigned SCK = adc_ctl_pkg::PIN_SCK;
    localparam logic [CW-1:0] PD_WAKE_C = CW'(PD_WAKE_CYCLES - 1);
    localparam int CONV_D  = int'(adc_ctl_pkg::CONV_CYC);
    localparam int CONV_M1 = CONV_D - 1;

    // pin sampling and edge detection
    logic [adc_ctl_pkg::PIN_N-1:0] pin_s;
    logic [adc_ctl_pkg::PIN_N-1:0] pin_q;

    pin_sync #(
        .WIDTH     (adc_ctl_pkg::PIN_N),
        .RESET_VAL (adc_ctl_pkg::PIN_RESET)
    ) u_pin_sync (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .async_i    ({sclk_i, cs_n_i, powerdown_reset_n_i,
                      conversion_start_i}),
        .sync_o     (pin_s)
    );

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_q <= adc_ctl_pkg::PIN_RESET;
        end else begin
            pin_q <= pin_s;
        end
    end

    wire cst_rise_w = pin_s[CST] & ~pin_q[CST];
    wire pd_fall_w  = ~pin_s[PD] & pin_q[PD];
    wire pd_rise_w  = pin_s[PD] & ~pin_q[PD];
    wire cs_fall_w  = ~pin_s[CS] & pin_q[CS];
    wire sck_fall_w = ~pin_s[SCK] & pin_q[SCK];
    wire cs_low_w   = ~pin_s[CS];
    // device state
    adc_ctl_pkg::state_type st_q;
    adc_ctl_pkg::state_type st_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          pend_q;
    logic [1:0]    avg_q;
    logic          wide_q;
    logic [1:0]    grp_q;
    logic          ready_q;
    wire in_acq_w  = (st_q == adc_ctl_pkg::ST_ACQ);
    wire in_cnv_w  = (st_q == adc_ctl_pkg::ST_CNV);
    wire in_low_w  = (st_q == adc_ctl_pkg::ST_LOW);
    wire in_wake_w = (st_q == adc_ctl_pkg::ST_WAKE);
    // conversion length comes from the core clock, not from sclk
    wire conv_done_w = in_cnv_w &&
        (cnt_q == adc_ctl_pkg::CONV_CYC - 1'b1);
    wire short_low_w = (cnt_q < adc_ctl_pkg::RST_MIN_CYC);
    wire pd_reached_w = (cnt_q >= adc_ctl_pkg::PD_MIN_CYC);
    // a pulse that ends on this edge is still a glitch
    wire cfg_clear_w = in_low_w && !pd_rise_w &&
        (cnt_q == adc_ctl_pkg::RST_MIN_CYC - 1'b1);
    // a result waiting for fifo room holds off new conversions
    wire start_ok_w = cst_rise_w && !pend_q;
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        case (st_q)
            adc_ctl_pkg::ST_ACQ: begin
                if (pd_fall_w) begin
                    st_d  = adc_ctl_pkg::ST_LOW;
                    cnt_d = '0;
                end else if (start_ok_w) begin
                    st_d  = adc_ctl_pkg::ST_CNV;
                    cnt_d = '0;
                end
            end
            adc_ctl_pkg::ST_CNV: begin
                // start edges inside a conversion are ignored
                if (pd_fall_w) begin
                    st_d  = adc_ctl_pkg::ST_LOW;
                    cnt_d = '0;
                end else if (conv_done_w) begin
                    st_d  = adc_ctl_pkg::ST_ACQ;
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            adc_ctl_pkg::ST_LOW: begin
                if (pd_rise_w) begin
                    if (short_low_w) begin
                        st_d  = adc_ctl_pkg::ST_ACQ;
                        cnt_d = '0;
                    end else if (pd_reached_w) begin
                        st_d  = adc_ctl_pkg::ST_WAKE;
                        cnt_d = PD_WAKE_C;
                    end else begin
                        st_d  = adc_ctl_pkg::ST_WAKE;
                        cnt_d = adc_ctl_pkg::RST_WAKE_CYC - 1'b1;
                    end
                end else if (!pd_reached_w) begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            adc_ctl_pkg::ST_WAKE: begin
                if (pd_fall_w) begin
                    st_d  = adc_ctl_pkg::ST_LOW;
                    cnt_d = '0;
                end else if (cnt_q == '0) begin
                    st_d = adc_ctl_pkg::ST_ACQ;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                st_d  = adc_ctl_pkg::ST_ACQ;
                cnt_d = '0;
            end
        endcase
    end
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q  <= adc_ctl_pkg::ST_ACQ;
            cnt_q <= '0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end
    // configuration; a qualified low pulse restores defaults
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            avg_q  <= adc_ctl_pkg::AVG_DEFAULT;
            wide_q <= adc_ctl_pkg::WIDE_DEFAULT;
        end else if (cfg_clear_w) begin
            avg_q  <= adc_ctl_pkg::AVG_DEFAULT;
            wide_q <= adc_ctl_pkg::WIDE_DEFAULT;
        end else if (config_write_i) begin
            avg_q  <= average_count_select_i;
            wide_q <= wide_read_i;
        end
    end
    // averaging group bookkeeping; code 01 behaves as no averaging
    wire [1:0] grp_end_w =
        (avg_q == adc_ctl_pkg::AVG_FOUR) ? 2'h3 :
        (avg_q == adc_ctl_pkg::AVG_TWO)  ? 2'h1 : 2'h0;
    wire [1:0] shift_w =
        (avg_q == adc_ctl_pkg::AVG_FOUR) ? 2'h2 :
        (avg_q == adc_ctl_pkg::AVG_TWO)  ? 2'h1 : 2'h0;
    wire grp_last_w  = (grp_q == grp_end_w);
    wire grp_done_w  = conv_done_w && grp_last_w;
    wire grp_reset_w = cfg_clear_w || config_write_i || pd_fall_w;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            grp_q <= '0;
        end else if (grp_reset_w) begin
            grp_q <= '0;
        end else if (conv_done_w) begin
            grp_q <= grp_last_w ? 2'h0 : grp_q + 2'h1;
        end
    end
    // per channel accumulate and mean
    logic [DW-1:0] samp_w [2];
    logic [DW-1:0] res_q  [2];
    logic [AW-1:0] acc_q  [2];

    assign samp_w[0] = sample_a_i;
    assign samp_w[1] = sample_b_i;

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        wire signed [AW-1:0] base_w =
            (grp_q == 2'h0) ? '0 : signed'(acc_q[ch]);
        wire signed [AW-1:0] sum_w =
            base_w + AW'(signed'(samp_w[ch]));
        // arithmetic shift floors negative means
        wire signed [AW-1:0] mean_w = sum_w >>> shift_w;

        always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                acc_q[ch] <= '0;
                res_q[ch] <= '0;
            end else if (conv_done_w) begin
                acc_q[ch] <= sum_w;
                if (grp_last_w) begin
                    res_q[ch] <= mean_w[DW-1:0];
                end
            end
        end
    end
    // finished result waits here until the fifo takes it
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic [2*DW-1:0] fifo_out_data;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= grp_done_w ||
                (pend_q && !fifo_in_ready && !cfg_clear_w);
        end
    end

    word_fifo #(
        .WIDTH (2 * DW),
        .DEPTH (adc_ctl_pkg::FIFO_DEPTH)
    ) u_result_fifo (
        .core_clk_i  (core_clk_i),
        .rstn_i      (rstn_i),
        .flush_i     (cfg_clear_w),
        .in_valid_i  (pend_q),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({res_q[0], res_q[1]}),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (cs_fall_w),
        .out_data_o  (fifo_out_data)
    );
    // ready: set by a finished group, cleared by select or reset
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= grp_done_w ||
                (ready_q && !cs_fall_w && !pd_fall_w);
        end
    end

    // serial readout, mode 0: launch on sclk fall, msb first
    logic [2*DW-1:0] last_q;
    logic [DW-1:0]   sh_q [2];

    // empty fifo repeats the last word handed out
    wire [2*DW-1:0] head_w =
        fifo_out_valid ? fifo_out_data : last_q;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last_q <= '0;
        end else if (cs_fall_w) begin
            last_q <= head_w;
        end
    end

    for (genvar ln = 0; ln < 2; ln++) begin : g_lane
        wire [DW-1:0] load_w = head_w[(2-ln)*DW-1 -: DW];

        always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                sh_q[ln] <= '0;
            end else if (cs_fall_w) begin
                sh_q[ln] <= load_w;
            end else if (sck_fall_w && cs_low_w) begin
                sh_q[ln] <= {sh_q[ln][DW-2:0], 1'b0};
            end
        end
    end

    assign sdo_a_o  = sh_q[0][DW-1];
    assign sdo_b_o  = sh_q[1][DW-1];
    assign sdo_oe_o = cs_low_w;

    // strobe is held low while selected or in wide read
    assign ready_strobe_o =
        ready_q && !cs_low_w && !wide_q;

    assign acquiring_o        = in_acq_w;
    assign converting_o       = in_cnv_w;
    assign powered_down_o     = in_low_w && pd_reached_w;
    assign averaging_config_o = avg_q;
    assign wide_read_o        = wide_q;

    default clocking cb_core @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);
    AST_RDY_MUX: assert property (cs_low_w |-> !ready_strobe_o)
        else $error("ready shown while select is low");
    AST_START_CNV: assert property (
        in_acq_w && cst_rise_w && !pend_q && !pd_fall_w
        |=> in_cnv_w && cnt_q == '0)
        else $error("start edge did not begin conversion");
    AST_ABORT: assert property (
        pd_fall_w && (in_acq_w || in_cnv_w) |=> in_low_w ##1 !conv_done_w)
        else $error("reset edge did not abort");
    AST_CONV_LEN: assert property (
        conv_done_w |-> $past(st_q, CONV_M1) == adc_ctl_pkg::ST_CNV
            && $past(st_q, CONV_D) != adc_ctl_pkg::ST_CNV)
        else $error("conversion length wrong");
    AST_DONE_ACQ: assert property (
        conv_done_w && !pd_fall_w |=> in_acq_w)
        else $error("conversion end not followed by acquisition");
    AST_GRP_READY: assert property (
        conv_done_w && avg_q == adc_ctl_pkg::AVG_TWO && grp_q == 2'h1
        |=> ready_q)
        else $error("two-sample ready missing");
    AST_HOLD_READY: assert property (
        conv_done_w && !grp_last_w |=> !$rose(ready_q) && $stable(res_q[0]))
        else $error("partial group changed ready or result");
    AST_AVG4_MEAN: assert property (
        conv_done_w && grp_last_w && avg_q == adc_ctl_pkg::AVG_FOUR
        |=> res_q[1] == DW'($past(g_ch[1].sum_w) >>> 2))
        else $error("four-sample mean wrong");
    AST_CFG_DEFAULT: assert property (
        cfg_clear_w |=> avg_q == adc_ctl_pkg::AVG_DEFAULT && !wide_q)
        else $error("config not restored by low pulse");
    AST_WAKE_HOLD: assert property (
        in_low_w && pd_rise_w && pd_reached_w
        |=> (in_wake_w && !pd_fall_w)[*8] or ##[1:8] pd_fall_w)
        else $error("left power-down before wake delay");
    AST_SDO_LOAD: assert property (
        cs_fall_w |=> sdo_a_o == $past(head_w[2*DW-1]) && sdo_oe_o)
        else $error("frame did not start with result msb");
endmodule // adc_conv_ctrl
`default_nettype wire

// [verif/adc_host_model.sv]
// host controller model: start pulses, power-down pin and mode-0 reads
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
    input  wire logic core_clk_i,
    input  wire logic sdo_a_i,
    input  wire logic sdo_b_i,
    output logic      conversion_start_o,
    output logic      powerdown_reset_n_o,
    output logic      cs_n_o,
    output logic      sclk_o
);
    initial begin
        conversion_start_o  = 1'b0;
        powerdown_reset_n_o = 1'b1;
        cs_n_o              = 1'b1;
        sclk_o              = 1'b0;
    end

    // held four clocks, well above the minimum high width
    task automatic pulse_start();
        @(posedge core_clk_i) #1 conversion_start_o = 1'b1;
        repeat (4) @(posedge core_clk_i);
        #1 conversion_start_o = 1'b0;
    endtask

    // sclk idles low outside frames; bits taken on the rising edge
    task automatic read_frame(output logic [15:0] a, output logic [15:0] b);
        @(posedge core_clk_i) #1 cs_n_o = 1'b0;
        #40;
        // no serial input pin: every frame is a no-op command
        for (int i = 0; i < 16; i++) begin
            sclk_o = 1'b1;
            a = {a[14:0], sdo_a_i};
            b = {b[14:0], sdo_b_i};
            #24 sclk_o = 1'b0;
            #24;
        end
        cs_n_o = 1'b1;
        repeat (4) @(posedge core_clk_i);
    endtask

    task automatic hold_pd_low(input int cycles);
        @(posedge core_clk_i) #1 powerdown_reset_n_o = 1'b0;
        repeat (cycles) @(posedge core_clk_i);
        #1 powerdown_reset_n_o = 1'b1;
    endtask
endmodule // adc_host_model
`default_nettype wire

// [verif/test_adc_conv_ctrl.sv]
// self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module test_adc_conv_ctrl;
    localparam int unsigned WAKE = 20;
    logic        core_clk_i, rstn_i, cst, pd_n, cs_n, sclk;
    logic [15:0] sample_a, sample_b, lfsr_q;
    logic        config_write, wide_read;
    logic [1:0]  avg_sel, avg_o;
    logic        ready, sdo_a, sdo_b, sdo_oe, acquire_state, convert_state, pdn_o, wide_o;
    logic [15:0] exp_a[$], exp_b[$];
    int          n_errors, n_tests, run_len, last_len, acc, n_acc;

    adc_conv_ctrl #(.PD_WAKE_CYCLES(WAKE)) uut (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .conversion_start_i(cst), .powerdown_reset_n_i(pd_n),
        .cs_n_i(cs_n), .sclk_i(sclk),
        .sample_a_i(sample_a), .sample_b_i(sample_b),
        .config_write_i(config_write), .average_count_select_i(avg_sel),
        .wide_read_i(wide_read), .ready_strobe_o(ready),
        .sdo_a_o(sdo_a), .sdo_b_o(sdo_b), .sdo_oe_o(sdo_oe),
        .acquiring_o(acquire_state), .converting_o(convert_state), .powered_down_o(pdn_o),
        .averaging_config_o(avg_o), .wide_read_o(wide_o));

    adc_host_model host (
        .core_clk_i(core_clk_i), .sdo_a_i(sdo_a), .sdo_b_i(sdo_b),
        .conversion_start_o(cst), .powerdown_reset_n_o(pd_n),
        .cs_n_o(cs_n), .sclk_o(sclk));

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    // length of the latest converting run
    always @(posedge core_clk_i) begin
        if (convert_state === 1'b1) begin
            run_len <= run_len + 1;
        end else begin
            if (run_len != 0) last_len <= run_len;
            run_len <= 0;
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] expv);
        n_tests++;
        if (seen !== expv) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, expv, seen);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic set_cfg(input logic [1:0] code, input logic wide);
        @(posedge core_clk_i) #1;
        avg_sel = code;
        wide_read = wide;
        config_write = 1'b1;
        @(posedge core_clk_i) #1 config_write = 1'b0;
        @(posedge core_clk_i) #1;
        check("avg_cfg", avg_o, code);
        check("wide_cfg", wide_o, wide);
    endtask

    task automatic wait_acq(input int lim, output int cnt);
        cnt = 0;
        while (acquire_state !== 1'b1 && cnt < lim) begin
            @(posedge core_clk_i) #1;
            cnt++;
        end
        check("acquiring", acquire_state, 1);
    endtask

    // wake time counted from release, sync delay allowed for
    task automatic wake_check(input int w);
        int cnt;
        wait_acq(w + 50, cnt);
        check("wake_min", 16'(cnt >= w), 1);
        check("wake_max", 16'(cnt <= w + 8), 1);
    endtask

    task automatic read_check();
        logic [15:0] a, b;
        fork
            host.read_frame(a, b);
            begin
                #200;
                check("ready_in_frame", ready, 0);
                check("sdo_oe", sdo_oe, 1);
            end
        join
        check("sdo_a", a, exp_a.pop_front());
        check("sdo_b", b, exp_b.pop_front());
    endtask

    // rdy: ready expected at group end, negative skips the check
    task automatic conv_group(input int n, input int rdy, input bit mid,
                              output int ok);
        int sa, sb, cnt;
        sa = 0;
        sb = 0;
        ok = 0;
        for (int k = 0; k < n; k++) begin
            @(posedge core_clk_i) #1;
            lfsr_q = lfsr_next(lfsr_q);
            sample_a = lfsr_q;
            lfsr_q = lfsr_next(lfsr_q);
            sample_b = lfsr_q;
            sa += $signed(sample_a);
            sb += $signed(sample_b);
            host.pulse_start();
            ok = (convert_state === 1'b1);
            if (mid) read_check();
            wait_acq(100, cnt);
            // run length is booked one edge after acquisition returns
            @(posedge core_clk_i) #1;
            check("conv_len", 16'(last_len), 16'(adc_ctl_pkg::CONV_CYC));
            if (rdy >= 0) check("ready", ready, (k == n - 1) ? rdy : 0);
        end
        if (ok != 0) begin
            exp_a.push_back(16'(sa >>> $clog2(n)));
            exp_b.push_back(16'(sb >>> $clog2(n)));
        end
    endtask

    initial begin
        #200000;
        n_errors++;
        final_report();
    end

    initial begin
        rstn_i = 1'b0;
        sample_a = 16'h0000;
        sample_b = 16'h0000;
        config_write = 1'b0;
        avg_sel = 2'h0;
        wide_read = 1'b0;
        lfsr_q = 16'h0035;
        repeat (16) @(posedge core_clk_i);
        #1 rstn_i = 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1;
        check("acq_after_reset", acquire_state, 1);
        check("idle_cnv", convert_state, 0);
        check("idle_pd", pdn_o, 0);
        check("avg_reset", avg_o, adc_ctl_pkg::AVG_DEFAULT);
        check("wide_reset", wide_o, adc_ctl_pkg::WIDE_DEFAULT);
        $display("test reset_values done");
        // codes 00 and 01 mean no averaging
        for (int c = 0; c < 4; c++) begin
            set_cfg(2'(c), 1'b0);
            repeat (2) begin
                conv_group(c == 3 ? 4 : (c == 2 ? 2 : 1), 1, 1'b0, acc);
                read_check();
            end
        end
        $display("test averaging_codes done");
        set_cfg(2'h0, 1'b1);
        conv_group(1, 0, 1'b0, acc);
        conv_group(1, 0, 1'b1, acc);
        read_check();
        $display("test wide_read done");
        set_cfg(2'h0, 1'b0);
        n_acc = 0;
        repeat (20) begin
            conv_group(1, -1, 1'b0, acc);
            n_acc += acc;
        end
        check("fifo_refused", 16'(n_acc < 20), 1);
        check("fifo_depth", 16'(n_acc >= adc_ctl_pkg::FIFO_DEPTH), 1);
        while (exp_a.size() > 0) read_check();
        $display("test buffer_fill done");
        set_cfg(2'h3, 1'b1);
        host.pulse_start();
        check("converting", convert_state, 1);
        host.hold_pd_low(20);
        check("aborted", convert_state, 0);
        wake_check(int'(adc_ctl_pkg::RST_WAKE_CYC));
        check("avg_default", avg_o, adc_ctl_pkg::AVG_DEFAULT);
        check("wide_default", wide_o, adc_ctl_pkg::WIDE_DEFAULT);
        set_cfg(2'h2, 1'b0);
        host.hold_pd_low(3);
        repeat (6) @(posedge core_clk_i);
        #1;
        check("glitch_kept", avg_o, 2'h2);
        $display("test reset_pulse done");
        fork
            host.hold_pd_low(500);
            begin
                repeat (450) @(posedge core_clk_i);
                #1;
                check("powered_down", pdn_o, 1);
            end
        join
        wake_check(WAKE);
        check("pd_default", avg_o, adc_ctl_pkg::AVG_DEFAULT);
        conv_group(1, 1, 1'b0, acc);
        read_check();
        $display("test power_down done");
        final_report();
    end
endmodule // test_adc_conv_ctrl
`default_nettype wire
